// *** bench/pmh_host_model.sv ***
`timescale 1ns/100ps
// ****************************************
// Host side of the command port
// ****************************************
module pmh_host_model #(
  parameter int OFF_WAIT = 200
) (
  // Clock
  input wire logic clk_sys,
  // Command port
  output logic cmdValid,
  output logic cmdWrite,
  output logic cmdInControl,
  output logic [7:0] cmdCode,
  output logic [15:0] cmdData,
  input wire logic rspValid,
  input wire logic [15:0] rspData
);
  initial begin
    cmdValid = 1'b0;
    cmdWrite = 1'b0;
    cmdInControl = 1'b0;
    cmdCode = 8'hff;
    cmdData = 16'hffff;
  end

  // Released lines show the inverse so stale values never look valid
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d, input logic ctl,
    output logic [15:0] r);
    @(posedge clk_sys);
    #1;
    cmdValid = 1'b1;
    cmdWrite = w;
    cmdInControl = ctl;
    cmdCode = c;
    cmdData = d;
    @(posedge clk_sys);
    #1;
    // The answer stands for one cycle after the taking edge only
    r = (!w && rspValid === 1'b1) ? rspData : 16'hxxxx;
    cmdValid = 1'b0;
    cmdWrite = ~w;
    cmdInControl = ~ctl;
    cmdCode = ~c;
    cmdData = ~d;
    @(posedge clk_sys);
    #1;
  endtask

  task automatic restart(output logic [15:0] r);
    xfer(1'b1, 8'h01, 16'h0000, 1'b1, r);
    repeat (OFF_WAIT) @(posedge clk_sys);
    xfer(1'b1, 8'h01, 16'h0080, 1'b1, r);
  endtask
endmodule

// *** bench/psu_mgmt_command_handler_tb.sv ***
`timescale 1ns/100ps
module psu_mgmt_command_handler_tb
  import pmh_pkg::*;
;
  logic clk_sys, rstn, cmdValid, cmdWrite, cmdInControl, rspValid, inputLost, outputEnable, alertN;
  logic [7:0] cmdCode, fanDemand, fanDuty;
  logic [15:0] cmdData, rspData, measVout, measIout, measTemp, measVin, r;
  int errors, total_checks, v;
  int m[int], f[int], u[int], fx[int];
  int fanReq[4] = '{'h00, 'h5a, 'h0a, 'h65};
  bit cf, oe;

  pmh_host_model #(.OFF_WAIT(200)) host (.clk_sys(clk_sys), .cmdValid(cmdValid), .cmdWrite(cmdWrite),
    .cmdInControl(cmdInControl), .cmdCode(cmdCode), .cmdData(cmdData), .rspValid(rspValid), .rspData(rspData));
  pmh_cmd_handler uut (.clk_sys(clk_sys), .rstn(rstn), .cmdValid(cmdValid), .cmdWrite(cmdWrite),
    .cmdInControl(cmdInControl), .cmdCode(cmdCode), .cmdData(cmdData), .rspValid(rspValid), .rspData(rspData),
    .measVout(measVout), .measIout(measIout), .measTemp(measTemp), .measVin(measVin), .inputLost(inputLost),
    .fanDemand(fanDemand), .outputEnable(outputEnable), .fanDuty(fanDuty), .alertN(alertN));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ****************************************
  // Checking and model
  // ****************************************
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      errors++;
      $display("BAD %s exp %h seen %h", n, e, s);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic rd(input int c, input int e);
    host.xfer(1'b0, 8'(c), 16'h0000, 1'b1, r);
    chk($sformatf("read %h", c), r, 16'(e));
  endtask

  // Refusals only raise the comm flag; accepted writes follow the setting table
  task automatic wr(input int c, input int d);
    bit ok;
    ok = (m['h10] == 0 || c == 'h10 || (m['h10] == 'h40 && c == 'h01)) && !fx.exists(c);
    if (c == 'h01) ok &= (d == 'h80 || d == 0);
    if (c == 'h3b) ok &= (d <= 'h64);
    if (c == 'h50) ok &= (d == 'h80 || d == 'hc0);
    if (c == 'h55) ok &= (d <= m[c]);
    if (c == 'h58 || c == 'h59) ok &= (d >= m[c]);
    host.xfer(1'b1, 8'(c), 16'(d), 1'b1, r);
    cf |= !ok;
    if (ok && c == 'h12) foreach (f[k]) m[k] = f[k];
    else if (ok && c == 'h14) m[d] = f[d];
    else if (ok && c == 'h17) u[d] = m[d];
    else if (ok && c == 'h18) m[d] = u[d];
    else if (ok) m[c] = d;
    if (ok && c == 'h01) oe = (d != 0);
  endtask

  task automatic clr(input bit ctl);
    host.xfer(1'b1, 8'h03, 16'h0000, ctl, r);
    if (ctl) cf = 0;
  endtask

  task automatic restart();
    host.restart(r);
    m['h01] = 'h80;
    oe = 1;
    cf = 0;
    tick(2);
  endtask

  function automatic int sumw(bit vw, bit vt);
    int b;
    b = (int'(!oe) << 6) | (int'(vt) << 5) | (int'(cf) << 1);
    if (b == 0 && vw) b = 1;
    return b | (((int'(vw | vt) << 7) | (int'(!oe) << 3)) << 8);
  endfunction

  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    #300000;
    errors++;
    conclude();
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    void'($urandom(32'h3b87));
    rstn = 1'b0;
    inputLost = 1'b0;
    measVout = 16'h0078;
    measIout = 16'h012c;
    measTemp = 16'h0064;
    measVin = 16'h01f4;
    fanDemand = 8'($urandom_range(50, 20));
    foreach (SET_CODE[i]) f[SET_CODE[i]] = FACTORY[i];
    foreach (f[k]) m[k] = f[k];
    foreach (f[k]) u[k] = f[k];
    m['h01] = 'h80;
    m['h10] = 0;
    fx = '{'h20: 'h17, 'h35: 'h1a4, 'h36: 'h168, 'h41: 'h80, 'h45: 'hc0, 'h47: 'hf8, 'h56: 'hc0, 'h5a: 'hc0};
    oe = 1;
    repeat (3) @(posedge clk_sys);
    #1;
    rstn = 1'b1;
    chk("outputEnable", outputEnable, 16'(oe)); // powers up on
    chk("alertN", alertN, 16'h0001); // no flags
    rd('h78, 0); // reset zero
    rd('h79, 0); // reset zero
    rd('h10, 0); // lock open
    foreach (fx[c]) rd(c, fx[c]); // fixed values
    foreach (f[c]) rd(c, m[c]); // defaults
    wr('h01, 'h55);
    rd('h01, m['h01]); // bad data ignored
    rd('h78, sumw(0, 0)); // comm flag
    chk("alertN", alertN, 16'h0000); // alert low
    clr(0);
    rd('h78, sumw(0, 0)); // not in control
    clr(1);
    rd('h78, sumw(0, 0)); // cleared
    wr('h20, 'h05);
    rd('h20, fx['h20]); // read-only kept
    rd('h78, sumw(0, 0)); // flagged
    v = $urandom_range(134, 125);
    wr('h10, 'h80);
    wr('h42, v);
    wr('h01, 0);
    rd('h42, m['h42]); // all blocked
    rd('h01, m['h01]); // output blocked
    wr('h10, 'h40);
    wr('h01, 0);
    tick(1);
    chk("outputEnable", outputEnable, 16'(oe)); // output allowed
    rd('h79, sumw(0, 0)); // output off
    wr('h10, 0);
    rd('h10, 0); // lock always written
    restart();
    chk("outputEnable", outputEnable, 16'(oe)); // back on
    rd('h78, sumw(0, 0)); // flags cleared
    wr('h42, v);
    wr('h17, 'h42);
    wr('h42, v + 1);
    wr('h18, 'h42);
    rd('h42, m['h42]); // user recall
    wr('h43, 'h6e);
    wr('h14, 'h42);
    rd('h42, m['h42]); // one restored
    rd('h43, m['h43]); // others kept
    wr('h55, m['h55] + 1);
    wr('h59, m['h59] - 1);
    wr('h50, 'h40);
    wr('h50, 'h80);
    foreach (f[c]) rd(c, m[c]); // limit checks
    wr('h12, 0);
    foreach (f[c]) rd(c, m[c]); // factory restored
    foreach (fanReq[i]) begin
      wr('h3b, fanReq[i]);
      tick(2);
      chk("fanDuty", fanDuty, 16'((m['h3b] == 0 || m['h3b] < fanDemand) ? fanDemand : m['h3b]));
    end
    rd('h78, sumw(0, 0)); // data error
    clr(1);
    measVout = 16'h0089;
    tick(3);
    chk("alertN", alertN, 16'h0000); // warning alert
    clr(1);
    tick(3);
    rd('h79, sumw(1, 0)); // flag set again
    measVout = 16'h008e;
    tick(3);
    oe = 0;
    measVout = 16'h0078;
    tick(3);
    chk("outputEnable", outputEnable, 16'(oe)); // latched off
    rd('h79, sumw(1, 1)); // fault bits
    restart();
    rd('h79, sumw(0, 0)); // latch cleared
    inputLost = 1'b1;
    measVout = 16'h005f;
    tick(3);
    chk("outputEnable", outputEnable, 16'h0001); // masked on input loss
    inputLost = 1'b0;
    tick(3);
    chk("outputEnable", outputEnable, 16'h0000); // undervolt trip
    measVout = 16'h0078;
    restart();
    chk("outputEnable", outputEnable, 16'(oe)); // restart
    conclude();
  end
endmodule

// *** include/pmh_pkg.sv ***
package pmh_pkg;

  // ****************************************
  // Command codes
  // ****************************************
  localparam logic [7:0] CMD_OUTPUT = 8'h01;
  localparam logic [7:0] CMD_CLEAR = 8'h03;
  localparam logic [7:0] CMD_LOCK = 8'h10;
  localparam logic [7:0] CMD_RESTORE_ALL = 8'h12;
  localparam logic [7:0] CMD_RESTORE_ONE = 8'h14;
  localparam logic [7:0] CMD_USER_SAVE = 8'h17;
  localparam logic [7:0] CMD_USER_RECALL = 8'h18;
  localparam logic [7:0] CMD_VOUT_FORMAT = 8'h20;
  localparam logic [7:0] CMD_IN_TURN_ON = 8'h35;
  localparam logic [7:0] CMD_IN_TURN_OFF = 8'h36;
  localparam logic [7:0] CMD_OOV_ACTION = 8'h41;
  localparam logic [7:0] CMD_OUV_ACTION = 8'h45;
  localparam logic [7:0] CMD_OOC_ACTION = 8'h47;
  localparam logic [7:0] CMD_IOV_ACTION = 8'h56;
  localparam logic [7:0] CMD_IUV_ACTION = 8'h5a;
  localparam logic [7:0] CMD_SUMMARY_BYTE = 8'h78;
  localparam logic [7:0] CMD_SUMMARY_WORD = 8'h79;

  // ****************************************
  // Data values
  // ****************************************
  localparam logic [7:0] OUT_ON = 8'h80;
  localparam logic [7:0] OUT_OFF = 8'h00;
  localparam logic [7:0] LOCK_NONE = 8'h00;
  localparam logic [7:0] LOCK_ALL = 8'h80;
  localparam logic [7:0] LOCK_ALLOW_OUT = 8'h40;
  localparam logic [15:0] ACT_LATCH = 16'h0080;
  localparam logic [15:0] ACT_HICCUP = 16'h00c0;
  localparam logic [15:0] ACT_OOV = 16'h0080;
  localparam logic [15:0] ACT_OUV = 16'h00c0;
  localparam logic [15:0] ACT_OOC = 16'h00f8;
  localparam logic [15:0] ACT_IOV = 16'h00c0;
  localparam logic [15:0] ACT_IUV = 16'h00c0;
  localparam logic [15:0] FAN_DUTY_MAX = 16'h0064;
  localparam logic [7:0] FAN_INTERNAL = 8'h00;
  localparam logic [2:0] VOUT_LINEAR = 3'h0;
  localparam logic [4:0] VOUT_EXP = 5'h17;
  localparam logic [15:0] IN_ON_LEVEL = 16'h01a4;
  localparam logic [15:0] IN_OFF_LEVEL = 16'h0168;
  localparam logic [15:0] READ_ERROR = 16'hffff;

  // ****************************************
  // Operating settings, tenths of a unit, then the overtemperature action code, fan setup and fan request in percent
  // ****************************************
  localparam int NSET = 15;
  localparam logic [3:0] IX_OOV_TRIP = 4'h0;
  localparam logic [3:0] IX_OOV_ALARM = 4'h1;
  localparam logic [3:0] IX_OUV_ALARM = 4'h2;
  localparam logic [3:0] IX_OUV_TRIP = 4'h3;
  localparam logic [3:0] IX_OOC_TRIP = 4'h4;
  localparam logic [3:0] IX_OOC_ALARM = 4'h5;
  localparam logic [3:0] IX_OT_TRIP = 4'h6;
  localparam logic [3:0] IX_OT_ALARM = 4'h7;
  localparam logic [3:0] IX_IOV_TRIP = 4'h8;
  localparam logic [3:0] IX_IOV_ALARM = 4'h9;
  localparam logic [3:0] IX_IUV_ALARM = 4'ha;
  localparam logic [3:0] IX_IUV_TRIP = 4'hb;
  localparam logic [3:0] IX_OT_ACTION = 4'hc;
  localparam logic [3:0] IX_FAN_SETUP = 4'hd;
  localparam logic [3:0] IX_FAN_REQ = 4'he;
  localparam logic [7:0] SET_CODE [NSET] = '{8'h40, 8'h42, 8'h43, 8'h44, 8'h46, 8'h4a, 8'h4f,
    8'h51, 8'h55, 8'h57, 8'h58, 8'h59, 8'h50, 8'h3a, 8'h3b};
  localparam logic [15:0] FACTORY [NSET] = '{16'h008c, 16'h0087, 16'h006c, 16'h0064, 16'h0294,
    16'h026c, 16'h0082, 16'h0078, 16'h02f8, 16'h02e4, 16'h0190, 16'h017c, 16'h00c0, 16'h0090, 16'h0000};

  // ****************************************
  // Sticky flag positions
  // ****************************************
  localparam int NFLAG = 14;
  localparam int FL_OOV_F = 0;
  localparam int FL_OOV_W = 1;
  localparam int FL_OUV_W = 2;
  localparam int FL_OUV_F = 3;
  localparam int FL_OOC_F = 4;
  localparam int FL_OOC_W = 5;
  localparam int FL_OT_F = 6;
  localparam int FL_OT_W = 7;
  localparam int FL_IOV_F = 8;
  localparam int FL_IOV_W = 9;
  localparam int FL_IUV_W = 10;
  localparam int FL_IUV_F = 11;
  localparam int FL_COMM_CMD = 12;
  localparam int FL_COMM_DATA = 13;

  // Returns {hit, index} of a setting addressed by its command code
  function automatic logic [4:0] setIndex(input logic [7:0] code);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < NSET; i++) begin
      if (SET_CODE[i] == code) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction

endpackage

// *** logic/pmh_cmd_handler.sv ***
`timescale 1ns/100ps
// Function
// RULE1 - 0x80 on, 0x00 off, power up on
// RULE2 - Host waits two seconds between off and on; pmh_host_model waits OFF_WAIT = 200 clocks (2 us)
// RULE3 - Off-then-on restart clears alarms and shutdowns
// RULE4 - Fault clear by controlling side clears all flags
// RULE5 - Persisting faults set their flags again
// RULE6 - Lock decodes 00, 80 and 40
// RULE7 - Lock resets open, lock writes always accepted
// RULE8 - Restore all reloads fixed factory defaults
// RULE9 - Restore one reloads only addressed setting
// RULE10 - User save and recall touch one setting
// RULE11 - Output format read-only, linear, fixed exponent
// RULE12 - Input turn-on and turn-off levels read-only
// RULE13 - Duty-cycle fan control, both fans together
// RULE14 - Fan request only raises, zero releases, checked
// RULE15 - Output overvoltage trip latches output off
// RULE16 - Output voltage warnings assert the alert
// RULE17 - Undervolt trip restarts, masked on input loss
// RULE18 - Overcurrent trip restarts, warning level alerts
// RULE19 - Overtemperature latched or hiccup, default hiccup
// RULE20 - Input limits only tightened, trips restart; the input overvoltage warning (0x57) is written unchecked
// RULE21 - Summary byte bit layout, reset zero
// RULE22 - Summary word low byte is summary byte
// RULE23 - Summary word high byte bit layout
// RULE24 - Locked or bad-data writes flag comm fault
// RULE25 - Read-only writes ignored, flagged invalid data
module pmh_cmd_handler
  import pmh_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Decoded management bus transactions
  input wire logic cmdValid,
  input wire logic cmdWrite,
  input wire logic cmdInControl,
  input wire logic [7:0] cmdCode,
  input wire logic [15:0] cmdData,
  output logic rspValid,
  output logic [15:0] rspData,
  // Measurements
  input wire logic [15:0] measVout,
  input wire logic [15:0] measIout,
  input wire logic [15:0] measTemp,
  input wire logic [15:0] measVin,
  input wire logic inputLost,
  input wire logic [7:0] fanDemand,
  // Power train control
  output logic outputEnable,
  output logic [7:0] fanDuty,
  output logic alertN
);

  // ****************************************
  // State
  // ****************************************
  logic [15:0] opSet_q [NSET];
  logic [15:0] userSet_q [NSET];
  logic [7:0] lock_q;
  logic opOn_q;
  logic ovLatch_q;
  logic otLatch_q;
  logic outEn_q;
  logic [NFLAG-1:0] flags_q;
  logic [NFLAG-1:0] cond;
  logic [7:0] fanDuty_q;
  logic alertN_q;
  logic rspValid_q;
  logic [15:0] rspData_q;

  // ****************************************
  // Command decode
  // ****************************************
  logic wr;
  logic rd;
  logic tHit;
  logic [3:0] tIdx;
  logic aHit;
  logic [3:0] aIdx;
  logic known;
  logic roCode;
  logic valOk;
  logic lockOk;
  logic doWrite;
  logic badData;
  logic clr;
  logic restart;
  logic [15:0] rdVal;
  logic rdHit;
  logic [7:0] sumByte;
  logic [7:0] sumHigh;

  assign wr = cmdValid & cmdWrite;
  assign rd = cmdValid & ~cmdWrite;
  assign {tHit, tIdx} = setIndex(cmdCode);
  assign {aHit, aIdx} = setIndex(cmdData[7:0]);

  // RULE6 - lock decode
  always_comb begin
    if (lock_q == LOCK_ALL) begin
      lockOk = (cmdCode == CMD_LOCK) || (cmdCode == CMD_CLEAR);
    end else if (lock_q == LOCK_ALLOW_OUT) begin
      lockOk = (cmdCode == CMD_LOCK) || (cmdCode == CMD_CLEAR) || (cmdCode == CMD_OUTPUT);
    end else begin
      lockOk = 1'b1;
    end
  end

  always_comb begin
    known = 1'b1;
    roCode = 1'b0;
    valOk = 1'b1;
    unique case (cmdCode)
      // RULE1 - only on and off values
      CMD_OUTPUT: valOk = (cmdData[7:0] == OUT_ON) || (cmdData[7:0] == OUT_OFF);
      CMD_CLEAR, CMD_RESTORE_ALL: valOk = 1'b1;
      // RULE6 - three legal lock values
      CMD_LOCK: valOk = cmdData[7:0] inside {LOCK_NONE, LOCK_ALL, LOCK_ALLOW_OUT};
      CMD_RESTORE_ONE, CMD_USER_SAVE, CMD_USER_RECALL: valOk = aHit;
      // RULE25 - read-only targets
      CMD_VOUT_FORMAT, CMD_IN_TURN_ON, CMD_IN_TURN_OFF, CMD_OOV_ACTION, CMD_OUV_ACTION,
      CMD_OOC_ACTION, CMD_IOV_ACTION, CMD_IUV_ACTION, CMD_SUMMARY_BYTE, CMD_SUMMARY_WORD: roCode = 1'b1;
      default: begin
        if (!tHit) begin
          known = 1'b0;
        // RULE20 - input trip may only be lowered
        end else if (tIdx == IX_IOV_TRIP) begin
          valOk = cmdData <= opSet_q[tIdx];
        // RULE20 - input undervolt levels may only be raised
        end else if (tIdx == IX_IUV_ALARM || tIdx == IX_IUV_TRIP) begin
          valOk = cmdData >= opSet_q[tIdx];
        // RULE19 - latched or hiccup only
        end else if (tIdx == IX_OT_ACTION) begin
          valOk = (cmdData == ACT_LATCH) || (cmdData == ACT_HICCUP);
        // RULE14 - percent up to full duty
        end else if (tIdx == IX_FAN_REQ) begin
          valOk = cmdData <= FAN_DUTY_MAX;
        end else if (tIdx == IX_FAN_SETUP) begin
          valOk = cmdData[15:8] == 8'h00;
        end
      end
    endcase
  end

  assign doWrite = wr & known & ~roCode & valOk & lockOk;
  // RULE24 - refused writes raise invalid data
  assign badData = wr & known & (roCode | ~valOk | ~lockOk);
  // RULE4 - side not in control cannot clear
  assign clr = doWrite & (cmdCode == CMD_CLEAR) & cmdInControl;
  assign restart = doWrite & (cmdCode == CMD_OUTPUT) & (cmdData[7:0] == OUT_ON) & ~opOn_q;

  // ****************************************
  // Write lock and output command
  // ****************************************
  // RULE7 - lock resets open and is always writable
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      lock_q <= LOCK_NONE;
    end else if (doWrite && cmdCode == CMD_LOCK) begin
      lock_q <= cmdData[7:0];
    end
  end

  // RULE1 - output command, on at power up
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      opOn_q <= 1'b1;
    end else if (doWrite && cmdCode == CMD_OUTPUT) begin
      opOn_q <= cmdData[7:0] == OUT_ON;
    end
  end

  // ****************************************
  // Operating and user settings
  // ****************************************
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      for (int i = 0; i < NSET; i++) begin
        opSet_q[i] <= FACTORY[i];
      end
    end else if (doWrite) begin
      unique case (cmdCode)
        // RULE8 - factory table is constant
        CMD_RESTORE_ALL: begin
          for (int i = 0; i < NSET; i++) begin
            opSet_q[i] <= FACTORY[i];
          end
        end
        // RULE9 - single setting restore
        CMD_RESTORE_ONE: opSet_q[aIdx] <= FACTORY[aIdx];
        // RULE10 - single setting recall
        CMD_USER_RECALL: opSet_q[aIdx] <= userSet_q[aIdx];
        default: begin
          if (tHit) begin
            opSet_q[tIdx] <= cmdData;
          end
        end
      endcase
    end
  end

  // RULE10 - single setting save
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      for (int i = 0; i < NSET; i++) begin
        userSet_q[i] <= FACTORY[i];
      end
    end else if (doWrite && cmdCode == CMD_USER_SAVE) begin
      userSet_q[aIdx] <= opSet_q[aIdx];
    end
  end

  // ****************************************
  // Fault detection
  // ****************************************
  always_comb begin
    cond = '0;
    cond[FL_OOV_F] = measVout > opSet_q[IX_OOV_TRIP];
    // RULE16 - output voltage warnings
    cond[FL_OOV_W] = measVout > opSet_q[IX_OOV_ALARM];
    cond[FL_OUV_W] = outEn_q & (measVout < opSet_q[IX_OUV_ALARM]);
    // RULE17 - masked while input power is lost
    cond[FL_OUV_F] = outEn_q & ~inputLost & (measVout < opSet_q[IX_OUV_TRIP]);
    // RULE18 - overcurrent trip and warning
    cond[FL_OOC_F] = measIout > opSet_q[IX_OOC_TRIP];
    cond[FL_OOC_W] = measIout > opSet_q[IX_OOC_ALARM];
    // RULE19 - hottest sensor against both levels
    cond[FL_OT_F] = measTemp > opSet_q[IX_OT_TRIP];
    cond[FL_OT_W] = measTemp > opSet_q[IX_OT_ALARM];
    cond[FL_IOV_F] = measVin > opSet_q[IX_IOV_TRIP];
    cond[FL_IOV_W] = measVin > opSet_q[IX_IOV_ALARM];
    cond[FL_IUV_W] = measVin < opSet_q[IX_IUV_ALARM];
    cond[FL_IUV_F] = measVin < opSet_q[IX_IUV_TRIP];
    cond[FL_COMM_CMD] = cmdValid & (cmdWrite ? ~known : ~rdHit);
    cond[FL_COMM_DATA] = badData;
  end

  // RULE5 - a live condition wins over the clear
  // RULE3 - restart clears alarms as well
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      flags_q <= '0;
    end else begin
      flags_q <= cond | (flags_q & ~{NFLAG{clr | restart}});
    end
  end

  // ****************************************
  // Shutdown control
  // ****************************************
  // RULE15 - overvoltage latches until restart
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      ovLatch_q <= 1'b0;
    end else if (cond[FL_OOV_F]) begin
      ovLatch_q <= 1'b1;
    end else if (restart) begin
      ovLatch_q <= 1'b0;
    end
  end

  // RULE19 - latched response holds until restart
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      otLatch_q <= 1'b0;
    end else if (cond[FL_OT_F] && opSet_q[IX_OT_ACTION] == ACT_LATCH) begin
      otLatch_q <= 1'b1;
    end else if (restart) begin
      otLatch_q <= 1'b0;
    end
  end

  // Restart responses hold the output off only while the cause stands;
  // the undervolt check then retries on each re-enable like a hiccup.
  // RULE17 - RULE18 - RULE20 - restart responses
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      outEn_q <= 1'b1;
    end else begin
      outEn_q <= opOn_q & ~ovLatch_q & ~otLatch_q & ~cond[FL_OUV_F] & ~cond[FL_OOC_F]
        & ~cond[FL_IOV_F] & ~cond[FL_IUV_F] & ~(cond[FL_OT_F] & (opSet_q[IX_OT_ACTION] == ACT_HICCUP));
    end
  end

  // ****************************************
  // Fan and alert
  // ****************************************
  // RULE13 - one duty drives both fans
  // RULE14 - request can only raise the duty
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      fanDuty_q <= FAN_INTERNAL;
    end else if (opSet_q[IX_FAN_REQ][7:0] == FAN_INTERNAL || opSet_q[IX_FAN_REQ][7:0] < fanDemand) begin
      fanDuty_q <= fanDemand;
    end else begin
      fanDuty_q <= opSet_q[IX_FAN_REQ][7:0];
    end
  end

  // RULE16 - any sticky flag pulls the alert low
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      alertN_q <= 1'b1;
    end else begin
      alertN_q <= ~(|flags_q);
    end
  end

  // ****************************************
  // Summary status and read back
  // ****************************************
  // RULE21 - summary byte
  always_comb begin
    sumByte[7] = 1'b0;
    sumByte[6] = ~outEn_q;
    sumByte[5] = flags_q[FL_OOV_F];
    sumByte[4] = flags_q[FL_OOC_F];
    sumByte[3] = flags_q[FL_IUV_F];
    sumByte[2] = flags_q[FL_OT_F] | flags_q[FL_OT_W];
    sumByte[1] = flags_q[FL_COMM_CMD] | flags_q[FL_COMM_DATA];
    sumByte[0] = ~(|sumByte[7:1]) & (|flags_q);
  end

  // RULE23 - summary word high byte
  assign sumHigh = {flags_q[FL_OOV_F] | flags_q[FL_OOV_W] | flags_q[FL_OUV_W] | flags_q[FL_OUV_F],
    flags_q[FL_OOC_F] | flags_q[FL_OOC_W], |flags_q[FL_IUV_F:FL_IOV_F], 1'b0, ~outEn_q, 3'h0};

  always_comb begin
    rdVal = 16'h0000;
    rdHit = 1'b1;
    unique case (cmdCode)
      CMD_OUTPUT: rdVal = {8'h00, opOn_q ? OUT_ON : OUT_OFF};
      CMD_LOCK: rdVal = {8'h00, lock_q};
      // RULE11 - linear format, fixed exponent
      CMD_VOUT_FORMAT: rdVal = {8'h00, VOUT_LINEAR, VOUT_EXP};
      // RULE12 - fixed input thresholds
      CMD_IN_TURN_ON: rdVal = IN_ON_LEVEL;
      CMD_IN_TURN_OFF: rdVal = IN_OFF_LEVEL;
      CMD_OOV_ACTION: rdVal = ACT_OOV;
      CMD_OUV_ACTION: rdVal = ACT_OUV;
      CMD_OOC_ACTION: rdVal = ACT_OOC;
      CMD_IOV_ACTION: rdVal = ACT_IOV;
      CMD_IUV_ACTION: rdVal = ACT_IUV;
      CMD_SUMMARY_BYTE: rdVal = {8'h00, sumByte};
      // RULE22 - byte low, flags high
      CMD_SUMMARY_WORD: rdVal = {sumHigh, sumByte};
      default: begin
        if (tHit) begin
          rdVal = opSet_q[tIdx];
        end else begin
          rdHit = 1'b0;
        end
      end
    endcase
  end

  // Unknown reads answer all ones rather than stale data
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      rspValid_q <= 1'b0;
      rspData_q <= 16'h0000;
    end else begin
      rspValid_q <= rd;
      if (rd) begin
        rspData_q <= rdHit ? rdVal : READ_ERROR;
      end
    end
  end

  assign rspValid = rspValid_q;
  assign rspData = rspData_q;
  assign outputEnable = outEn_q;
  assign fanDuty = fanDuty_q;
  assign alertN = alertN_q;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  a_output_off_cmd: assert property (doWrite && cmdCode == CMD_OUTPUT && cmdData[7:0] == OUT_OFF
    |=> ##1 !outputEnable) else $error("output stayed on after off"); // RULE1
  a_restart_unlatch: assert property (restart && !cond[FL_OOV_F]
    |=> !ovLatch_q) else $error("restart left latch set"); // RULE3
  a_clear_to_live: assert property (clr |=> flags_q == $past(cond))
    else $error("clear left stale flags"); // RULE4
  a_fault_reflag: assert property (cond[FL_OT_F] |=> flags_q[FL_OT_F])
    else $error("persisting fault not flagged"); // RULE5
  a_lock_blocks: assert property (wr && lock_q == LOCK_ALL && cmdCode == CMD_OUTPUT
    |=> opOn_q == $past(opOn_q) && flags_q[FL_COMM_DATA]) else $error("locked write took effect"); // RULE6
  a_lock_write: assert property (wr && cmdCode == CMD_LOCK && cmdData[7:0] == LOCK_ALL
    |=> lock_q == LOCK_ALL) else $error("lock write refused"); // RULE7
  a_restore_all: assert property (doWrite && cmdCode == CMD_RESTORE_ALL
    |=> opSet_q[IX_OOV_TRIP] == FACTORY[IX_OOV_TRIP]) else $error("restore all failed"); // RULE8
  a_fan_floor: assert property (1'b1 |=> fanDuty >= $past(fanDemand))
    else $error("fan below internal demand"); // RULE14
  a_ov_shutdown: assert property (cond[FL_OOV_F] |=> ##1 !outputEnable [*2])
    else $error("overvoltage did not shut down"); // RULE15
  a_alert_follows: assert property (|flags_q |=> !alertN)
    else $error("alert not asserted"); // RULE16
  a_iov_lower_only: assert property (wr && cmdCode == SET_CODE[IX_OOV_TRIP + 4'h8]
    && cmdData > opSet_q[IX_IOV_TRIP] |=> $stable(opSet_q[IX_IOV_TRIP])) else $error("input trip raised"); // RULE20
  a_ro_write: assert property (wr && roCode |=> flags_q[FL_COMM_DATA] && $stable(opSet_q[IX_OT_ACTION]))
    else $error("read-only write not flagged"); // RULE25

  c_restart: cover property (restart);
  c_clear: cover property (clr ##1 |flags_q);
  c_lock_refused: cover property (wr && !lockOk);
  c_ot_latch: cover property ($rose(otLatch_q));

endmodule
